// [logic/hdp_pkg.sv]
/*
  Constants shared by the endpoint status-flag block: register offsets,
  field positions, reset values and bank depth.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned offsets.
*/
package hdp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_EP_RST  = 8'h04;
  localparam logic [7:0] OFS_EP_DIS  = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_SET     = 8'h10;
  localparam logic [7:0] OFS_CLR     = 8'h14;
  localparam logic [7:0] OFS_EVENT   = 8'h18;

  // Flag / event bit positions (status, event and mask share them)
  localparam int BIT_RX_KILL  = 0;
  localparam int BIT_IN_DONE  = 1;
  localparam int BIT_TX_TRERR = 2;
  localparam int BIT_FLOW     = 3;
  localparam int BIT_CRC      = 4;
  localparam int NFLAGS       = 5;

  // Control register fields above the mask field
  localparam int BIT_EP_EN    = 8;
  localparam int BIT_DIR_IN   = 9;
  localparam int BIT_ISO      = 10;
  localparam int BIT_HB_ISO   = 11;

  // Status register fields
  localparam int POS_BUSY     = 16;
  localparam int POS_OUTCNT   = 20;
  localparam int POS_CURRENT_BANK_INDEX    = 24;

  // Bank depth and counter reset value
  localparam logic [1:0] BANKS   = 2'h3;
  localparam logic [1:0] CNT_RST = 2'h0;

  // Reset values
  localparam logic [11:0] CTRL_RST  = 12'h000;
  localparam logic [4:0]  FLAGS_RST = 5'h00;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [logic/hdp_endpoint_flags.sv]
/*
  One endpoint's status-flag logic of the high-speed device port, with an
  AXI4-Lite register slave and a level interrupt output.
  Assumes the packet engine runs on mclk and gives single-cycle pulses.
*/
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module hdp_endpoint_flags (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Packet engine
  input  wire logic        usbBusReset,
  input  wire logic        outPktIn,
  input  wire logic        outCrcBad,
  input  wire logic        outToggleBad,
  input  wire logic        inToken,
  input  wire logic        inSending,
  input  wire logic        inPktSent,
  // Interrupt
  output logic             irq
);

  function automatic logic [1:0] nextPtr(input logic [1:0] p);
    nextPtr = (p == hdp_pkg::BANKS - 2'h1) ? 2'h0 : p + 2'h1;
  endfunction

  // Bus state
  logic        awHeld_q, awHeld_d;
  logic        wHeld_q, wHeld_d;
  logic [7:0]  awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic        bValid_q, bValid_d;
  logic [1:0]  bResp_q, bResp_d;
  logic        rValid_q, rValid_d;
  logic [31:0] rData_q, rData_d;
  logic [1:0]  rResp_q, rResp_d;
  // Endpoint state
  logic [11:0] ctrl_q, ctrl_d;
  logic [1:0]  outCnt_q, outCnt_d;
  logic [1:0]  wrPtr_q, wrPtr_d;
  logic [1:0]  rdPtr_q, rdPtr_d;
  logic [2:0]  bad_q, bad_d;
  logic [1:0]  busyCnt_q, busyCnt_d;
  logic        kill_q, kill_d;
  logic        inDone_q, inDone_d;
  logic        flow_q, flow_d;
  logic        crc_q, crc_d;
  logic [4:0]  evt_q, evt_d;

  logic        wrFire, rdFire, wrStrb;
  logic [7:0]  wrAddr;
  logic [31:0] wrData;
  logic [4:0]  flags, evtSet;
  logic        epClear, dirIn, iso, stored, txRdy, txRdyNext;

  assign dirIn  = ctrl_q[hdp_pkg::BIT_DIR_IN];
  assign iso    = ctrl_q[hdp_pkg::BIT_ISO];
  assign wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
  assign wrData = wHeld_q ? wData_q : s_axi_wdata;
  assign wrFire = (awHeld_q | s_axi_awvalid) & (wHeld_q | s_axi_wvalid) & ~bValid_q;
  assign rdFire = s_axi_arvalid & ~rValid_q;
  assign wrStrb = s_axi_wstrb[0] | wHeld_q;

  assign s_axi_awready = ~awHeld_q & ~bValid_q;
  assign s_axi_wready  = ~wHeld_q & ~bValid_q;
  assign s_axi_arready = ~rValid_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

  // TX ready reads set only while no bank is left free
  assign txRdy = busyCnt_q == hdp_pkg::BANKS;
  assign flags = {crc_q, flow_q,
                  dirIn ? txRdy : (outCnt_q != hdp_pkg::CNT_RST) & bad_q[rdPtr_q],
                  inDone_q,
                  dirIn ? kill_q : (outCnt_q != hdp_pkg::CNT_RST)};

  always_comb begin
    awHeld_d = awHeld_q;
    wHeld_d  = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d  = wData_q;
    bValid_d = bValid_q;
    bResp_d  = bResp_q;
    rValid_d = rValid_q;
    rData_d  = rData_q;
    rResp_d  = rResp_q;
    if (s_axi_awvalid & s_axi_awready) begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready) begin
      wHeld_d = 1'b1;
      wData_d = s_axi_wdata;
    end
    if (wrFire) begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = (wrAddr <= hdp_pkg::OFS_EVENT && wrAddr[1:0] == 2'h0)
                 ? hdp_pkg::RESP_OKAY : hdp_pkg::RESP_SLVERR;
    end else if (bValid_q & s_axi_bready) begin
      bValid_d = 1'b0;
    end
    if (rdFire) begin
      rValid_d = 1'b1;
      rResp_d  = hdp_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        hdp_pkg::OFS_CTRL:   rData_d = {20'h0_0000, ctrl_q};
        hdp_pkg::OFS_STATUS: rData_d = {6'h00, rdPtr_q, 2'h0, outCnt_q, 2'h0, busyCnt_q,
                                        11'h000, flags};
        hdp_pkg::OFS_EVENT:  rData_d = {27'h000_0000, evt_q};
        hdp_pkg::OFS_EP_RST, hdp_pkg::OFS_EP_DIS,
        hdp_pkg::OFS_SET, hdp_pkg::OFS_CLR: rData_d = 32'h0000_0000;
        default: begin
          rData_d = 32'h0000_0000;
          rResp_d = hdp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rValid_q & s_axi_rready) begin
      rValid_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q  <= 32'h0000_0000;
      bValid_q <= 1'b0;
      bResp_q  <= hdp_pkg::RESP_OKAY;
      rValid_q <= 1'b0;
      rData_q  <= 32'h0000_0000;
      rResp_q  <= hdp_pkg::RESP_OKAY;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q  <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q  <= wData_d;
      bValid_q <= bValid_d;
      bResp_q  <= bResp_d;
      rValid_q <= rValid_d;
      rData_q  <= rData_d;
      rResp_q  <= rResp_d;
    end
  end

  // Software strobes; writes qualified by the low byte lane unless the data beat was held
  logic wrCtrl, wrRst, wrDis, setKill, setTx, clrRx, clrDone, clrFlow, rdEvt;
  assign wrCtrl  = wrFire & wrStrb & (wrAddr == hdp_pkg::OFS_CTRL);
  assign wrRst   = wrFire & wrStrb & (wrAddr == hdp_pkg::OFS_EP_RST) & wrData[0];
  assign wrDis   = wrFire & wrStrb & (wrAddr == hdp_pkg::OFS_EP_DIS) & wrData[0];
  assign setKill = wrFire & wrStrb & (wrAddr == hdp_pkg::OFS_SET) & wrData[hdp_pkg::BIT_RX_KILL];
  assign setTx   = wrFire & wrStrb & (wrAddr == hdp_pkg::OFS_SET) & wrData[hdp_pkg::BIT_TX_TRERR];
  assign clrRx   = wrFire & wrStrb & (wrAddr == hdp_pkg::OFS_CLR) & wrData[hdp_pkg::BIT_RX_KILL];
  assign clrDone = wrFire & wrStrb & (wrAddr == hdp_pkg::OFS_CLR) & wrData[hdp_pkg::BIT_IN_DONE];
  assign clrFlow = wrFire & wrStrb & (wrAddr == hdp_pkg::OFS_CLR) & wrData[hdp_pkg::BIT_FLOW];
  assign rdEvt   = rdFire & (s_axi_araddr == hdp_pkg::OFS_EVENT);

  assign epClear = usbBusReset | wrRst | wrDis;
  // store when a bank is free
  assign stored  = outPktIn & ~dirIn & ctrl_q[hdp_pkg::BIT_EP_EN] & (outCnt_q != hdp_pkg::BANKS);

  always_comb begin
    logic [1:0] busyNext;
    logic       sentNow, killNow;
    busyNext  = busyCnt_q;
    sentNow   = inPktSent & dirIn & (busyCnt_q != hdp_pkg::CNT_RST);
    killNow   = 1'b0;
    ctrl_d    = wrCtrl ? wrData[11:0] : ctrl_q;
    outCnt_d  = outCnt_q;
    wrPtr_d   = wrPtr_q;
    rdPtr_d   = rdPtr_q;
    bad_d     = bad_q;
    kill_d    = kill_q | (setKill & dirIn);
    crc_d     = crc_q;
    evtSet    = 5'h00;
    if (stored) begin
      wrPtr_d  = nextPtr(wrPtr_q);
      // mark a bank holding a bad toggle sequence
      bad_d[wrPtr_q] = outToggleBad & ctrl_q[hdp_pkg::BIT_HB_ISO];
      if (iso) begin
        crc_d = outCrcBad;
      end
    end
    // firmware clear pops the current bank
    // count keeps flag up while banks remain
    if (clrRx & ~dirIn & (outCnt_q != hdp_pkg::CNT_RST)) begin
      rdPtr_d = nextPtr(rdPtr_q);
    end
    outCnt_d = outCnt_q + {1'b0, stored}
               - {1'b0, clrRx & ~dirIn & (outCnt_q != hdp_pkg::CNT_RST)};
    if (sentNow) begin
      busyNext = busyNext - 2'h1;
    end
    if (kill_q) begin
      if (busyCnt_q == hdp_pkg::CNT_RST) begin
        kill_d = 1'b0;
      end else if (busyCnt_q == 2'h1 & (inSending | inPktSent)) begin
        // refused, the packet goes out instead
        kill_d = ~inPktSent;
      end else begin
        // drop one bank, count goes down
        // with no send pending the last bank goes
        killNow  = 1'b1;
        kill_d   = 1'b0;
        busyNext = busyNext - 2'h1;
      end
    end
    if (setTx & dirIn & (busyNext != hdp_pkg::BANKS)) begin
      busyNext = busyNext + 2'h1;
    end
    busyCnt_d = busyNext;
    txRdyNext = busyNext == hdp_pkg::BANKS;
    // done flag, set wins over clear
    inDone_d  = sentNow | (inDone_q & ~clrDone);
    // underflow on iso IN, overflow on iso OUT
    flow_d    = (iso & dirIn & inToken & (busyCnt_q == hdp_pkg::CNT_RST))
              | (iso & ~dirIn & outPktIn & (outCnt_q == hdp_pkg::BANKS))
              | (flow_q & ~clrFlow);
    evtSet[hdp_pkg::BIT_RX_KILL]  = stored & (outCnt_q == hdp_pkg::CNT_RST);
    evtSet[hdp_pkg::BIT_IN_DONE]  = sentNow & ~inDone_q;
    // event on hardware clear of TX ready
    evtSet[hdp_pkg::BIT_TX_TRERR] = txRdy & ~txRdyNext & (sentNow | killNow);
    evtSet[hdp_pkg::BIT_FLOW]     = flow_d & ~flow_q;
    evtSet[hdp_pkg::BIT_CRC]      = stored & iso & outCrcBad;
    // Read clears, new events in the same cycle survive
    evt_d = evtSet | (rdEvt ? 5'h00 : evt_q);
    if (epClear) begin
      outCnt_d  = hdp_pkg::CNT_RST;
      wrPtr_d   = hdp_pkg::CNT_RST;
      rdPtr_d   = hdp_pkg::CNT_RST;
      bad_d     = 3'h0;
      busyCnt_d = hdp_pkg::CNT_RST;
      kill_d    = 1'b0;
      inDone_d  = 1'b0;
      flow_d    = 1'b0;
      crc_d     = 1'b0;
    end
    if (wrDis | usbBusReset) begin
      ctrl_d[hdp_pkg::BIT_EP_EN] = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q    <= hdp_pkg::CTRL_RST;
      outCnt_q  <= hdp_pkg::CNT_RST;
      wrPtr_q   <= hdp_pkg::CNT_RST;
      rdPtr_q   <= hdp_pkg::CNT_RST;
      bad_q     <= 3'h0;
      busyCnt_q <= hdp_pkg::CNT_RST;
      kill_q    <= 1'b0;
      inDone_q  <= 1'b0;
      flow_q    <= 1'b0;
      crc_q     <= 1'b0;
      evt_q     <= hdp_pkg::FLAGS_RST;
    end else begin
      ctrl_q    <= ctrl_d;
      outCnt_q  <= outCnt_d;
      wrPtr_q   <= wrPtr_d;
      rdPtr_q   <= rdPtr_d;
      bad_q     <= bad_d;
      busyCnt_q <= busyCnt_d;
      kill_q    <= kill_d;
      inDone_q  <= inDone_d;
      flow_q    <= flow_d;
      crc_q     <= crc_d;
      evt_q     <= evt_d;
    end
  end

  // Mask is the low field of the control register, bits 4:0
  assign irq = |(evt_q & ctrl_q[hdp_pkg::NFLAGS-1:0]);

  chk_rx_set: assert property (@(posedge mclk) disable iff (!rst_n)
    stored & ~epClear |=> outCnt_q != 2'h0) else $error("Stored packet left flag low");
  chk_rx_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    clrRx & ~dirIn & (outCnt_q == 2'h2) & ~epClear |=> outCnt_q != 2'h0)
    else $error("Received flag dropped with bank pending");
  chk_rx_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    stored & (outCnt_q == 2'h0) & ctrl_q[0] & ~wrCtrl |=> irq)
    else $error("No interrupt on received flag");
  chk_ep_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrRst | wrDis) |=> (flags[1] == 1'b0) && !flow_q && !crc_q && busyCnt_q == 2'h0)
    else $error("Endpoint reset left flags");
  chk_bus_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    usbBusReset |=> outCnt_q == 2'h0 && !inDone_q && !kill_q)
    else $error("Bus reset left flags");
  chk_kill_dec: assert property (@(posedge mclk) disable iff (!rst_n)
    kill_q & (busyCnt_q == 2'h2) & ~inPktSent & ~setTx & ~epClear |=> busyCnt_q == 2'h1)
    else $error("Kill did not drop a bank");
  chk_kill_refuse: assert property (@(posedge mclk) disable iff (!rst_n)
    kill_q & (busyCnt_q == 2'h1) & inSending & ~inPktSent & ~epClear & ~setTx
    |=> busyCnt_q == 2'h1 && kill_q) else $error("Kill taken during transmit");
  chk_in_done: assert property (@(posedge mclk) disable iff (!rst_n)
    inPktSent & dirIn & (busyCnt_q != 2'h0) & ~epClear |=> inDone_q)
    else $error("Sent packet did not set done");
  chk_flow_err: assert property (@(posedge mclk) disable iff (!rst_n)
    iso & dirIn & inToken & (busyCnt_q == 2'h0) & ~epClear |=> flow_q)
    else $error("Underflow not flagged");
  chk_crc_upd: assert property (@(posedge mclk) disable iff (!rst_n)
    stored & iso & ~epClear |=> crc_q == $past(outCrcBad)) else $error("CRC flag stale");

  cov_out_two: cover property (@(posedge mclk) disable iff (!rst_n) outCnt_q == 2'h2);
  cov_kill_two: cover property (@(posedge mclk) disable iff (!rst_n)
    kill_q & (busyCnt_q == 2'h2) & inPktSent);
  cov_irq: cover property (@(posedge mclk) disable iff (!rst_n) $rose(irq));
endmodule

// [testbench/hdp_host_model.sv]
/*
  Host-side model of the endpoint bench: drives OUT packets, IN tokens and
  bus reset as single-cycle strobes on the packet engine inputs.
  Assumes the engine samples every strobe on the rising edge of mclk.
*/
`timescale 1ns/1ps
module hdp_host_model (
  // Clock
  input  wire logic mclk,
  // Engine strobes
  output logic      usbBusReset,
  output logic      outPktIn,
  output logic      outCrcBad,
  output logic      outToggleBad,
  output logic      inToken,
  output logic      inSending,
  output logic      inPktSent
);
  initial begin
    usbBusReset  = 1'b0;
    outPktIn     = 1'b0;
    outCrcBad    = 1'b1;
    outToggleBad = 1'b1;
    inToken      = 1'b0;
    inSending    = 1'b0;
    inPktSent    = 1'b0;
  end

  // Qualifiers flip outside packets so no stale value looks valid
  task automatic outPacket(input logic crc, input logic tog);
    @(posedge mclk);
    outPktIn     <= 1'b1;
    outCrcBad    <= crc;
    outToggleBad <= tog;
    @(posedge mclk);
    outPktIn     <= 1'b0;
    outCrcBad    <= ~crc;
    outToggleBad <= ~tog;
  endtask

  task automatic inXfer(input int len);
    @(posedge mclk);
    inToken   <= 1'b1;
    inSending <= 1'b1;
    @(posedge mclk);
    inToken <= 1'b0;
    repeat (len) @(posedge mclk);
    inSending <= 1'b0;
    inPktSent <= 1'b1;
    @(posedge mclk);
    inPktSent <= 1'b0;
  endtask

  task automatic busReset();
    @(posedge mclk);
    usbBusReset <= 1'b1;
    @(posedge mclk);
    usbBusReset <= 1'b0;
  endtask
endmodule

// [testbench/hdp_endpoint_flags_tb_top.sv]
/*
  Self-checking bench of the endpoint flags block over AXI4-Lite.
  Assumes the host model drives the engine strobes on mclk.
*/
`timescale 1ns/1ps
module hdp_endpoint_flags_tb_top;
  logic        mclk;
  logic        rst_n;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        usbBusReset, outPktIn, outCrcBad, outToggleBad;
  logic        inToken, inSending, inPktSent, irq;
  int          n_fail;
  int          compares;
  logic [31:0] rng;
  logic [31:0] rd;
  logic [1:0]  rsp;
  logic [1:0]  nb;

  hdp_endpoint_flags u_hdp_endpoint_flags (
    .mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .usbBusReset(usbBusReset),
    .outPktIn(outPktIn), .outCrcBad(outCrcBad), .outToggleBad(outToggleBad),
    .inToken(inToken), .inSending(inSending), .inPktSent(inPktSent), .irq(irq));

  hdp_host_model u_hdp_host_model (
    .mclk(mclk), .usbBusReset(usbBusReset), .outPktIn(outPktIn),
    .outCrcBad(outCrcBad), .outToggleBad(outToggleBad), .inToken(inToken),
    .inSending(inSending), .inPktSent(inPktSent));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] fb(input int i);
    return 32'h0000_0001 << i;
  endfunction
  function automatic logic [31:0] bz(input logic [1:0] n);
    return {30'h0, n} << hdp_pkg::POS_BUSY;
  endfunction

  task automatic summarize();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Handshakes judged at the rising edge, before that edge's updates land
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
      if (n > 50) begin n_fail++; summarize(); end
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    check({30'h0, rsp}, {30'h0, er});
  endtask
  task automatic rdReg(input logic [7:0] a, input logic [1:0] er);
    int n;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 50) begin n_fail++; summarize(); end
    end while (!s_axi_rvalid);
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check({30'h0, rsp}, {30'h0, er});
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    rdReg(hdp_pkg::OFS_STATUS, hdp_pkg::RESP_OKAY);
    check(rd & m, e);
  endtask

  initial begin
    rst_n = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    n_fail = 0;
    compares = 0;
    rng = 32'h0000_0019;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rdReg(hdp_pkg::OFS_STATUS, hdp_pkg::RESP_OKAY);
    check(rd, 32'h0000_0000);
    rdReg(hdp_pkg::OFS_EVENT, hdp_pkg::RESP_OKAY);
    check(rd, 32'h0000_0000);
    rdReg(8'h1C, hdp_pkg::RESP_SLVERR);
    wr(8'h20, 32'h0000_0000, hdp_pkg::RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      wr(hdp_pkg::OFS_CTRL, rng, hdp_pkg::RESP_OKAY);
      rdReg(hdp_pkg::OFS_CTRL, hdp_pkg::RESP_OKAY);
      check(rd, rng & 32'h0000_0FFF);
    end
    $display("test registers done");
    wr(hdp_pkg::OFS_CTRL, fb(0) | fb(hdp_pkg::BIT_EP_EN), hdp_pkg::RESP_OKAY);
    u_hdp_host_model.outPacket(1'b0, 1'b0);
    st(fb(0), fb(0));
    check({31'h0, irq}, 32'h0000_0001);
    rdReg(hdp_pkg::OFS_EVENT, hdp_pkg::RESP_OKAY);
    check({31'h0, irq}, 32'h0000_0000);
    u_hdp_host_model.outPacket(1'b0, 1'b0);
    wr(hdp_pkg::OFS_CLR, fb(0), hdp_pkg::RESP_OKAY);
    st(fb(0), fb(0));
    wr(hdp_pkg::OFS_CLR, fb(0), hdp_pkg::RESP_OKAY);
    st(fb(0), 32'h0000_0000);
    wr(hdp_pkg::OFS_CTRL, fb(hdp_pkg::BIT_EP_EN), hdp_pkg::RESP_OKAY);
    rng = xs(rng);
    nb = 2'(rng % 3) + 2'h1;
    repeat (nb) u_hdp_host_model.outPacket(1'b0, 1'b0);
    check({31'h0, irq}, 32'h0000_0000);
    st(32'h0000_0003 << hdp_pkg::POS_OUTCNT, {30'h0, nb} << hdp_pkg::POS_OUTCNT);
    wr(hdp_pkg::OFS_EP_RST, fb(0), hdp_pkg::RESP_OKAY);
    st(32'h0030_001F, 32'h0000_0000);
    $display("test out flags done");
    wr(hdp_pkg::OFS_CTRL, fb(hdp_pkg::BIT_EP_EN) | fb(hdp_pkg::BIT_ISO), hdp_pkg::RESP_OKAY);
    u_hdp_host_model.outPacket(1'b1, 1'b0);
    st(fb(hdp_pkg::BIT_CRC), fb(hdp_pkg::BIT_CRC));
    u_hdp_host_model.outPacket(1'b0, 1'b0);
    st(fb(hdp_pkg::BIT_CRC), 32'h0000_0000);
    repeat (2) u_hdp_host_model.outPacket(1'b0, 1'b0);
    st(fb(hdp_pkg::BIT_FLOW), fb(hdp_pkg::BIT_FLOW));
    wr(hdp_pkg::OFS_EP_DIS, fb(0), hdp_pkg::RESP_OKAY);
    st(32'h0030_001F, 32'h0000_0000);
    rdReg(hdp_pkg::OFS_CTRL, hdp_pkg::RESP_OKAY);
    check(rd & fb(hdp_pkg::BIT_EP_EN), 32'h0000_0000);
    wr(hdp_pkg::OFS_CTRL, 32'h0000_0D00, hdp_pkg::RESP_OKAY);
    u_hdp_host_model.outPacket(1'b0, 1'b1);
    u_hdp_host_model.outPacket(1'b0, 1'b0);
    st(fb(hdp_pkg::BIT_TX_TRERR), fb(hdp_pkg::BIT_TX_TRERR));
    wr(hdp_pkg::OFS_CLR, fb(0), hdp_pkg::RESP_OKAY);
    st(fb(hdp_pkg::BIT_TX_TRERR), 32'h0000_0000);
    u_hdp_host_model.busReset();
    st(32'h0030_001F, 32'h0000_0000);
    $display("test iso out done");
    wr(hdp_pkg::OFS_CTRL, 32'h0000_0304, hdp_pkg::RESP_OKAY);
    repeat (3) wr(hdp_pkg::OFS_SET, fb(2), hdp_pkg::RESP_OKAY);
    st(fb(2) | bz(2'h3), fb(2) | bz(2'h3));
    u_hdp_host_model.inXfer(2);
    st(fb(1) | fb(2) | bz(2'h3), fb(1) | bz(2'h2));
    check({31'h0, irq}, 32'h0000_0001);
    wr(hdp_pkg::OFS_SET, fb(0), hdp_pkg::RESP_OKAY);
    repeat (2) @(posedge mclk);
    st(fb(0) | bz(2'h3), bz(2'h1));
    wr(hdp_pkg::OFS_SET, fb(2), hdp_pkg::RESP_OKAY);
    wr(hdp_pkg::OFS_CLR, fb(1), hdp_pkg::RESP_OKAY);
    fork
      u_hdp_host_model.inXfer(6);
      wr(hdp_pkg::OFS_SET, fb(0), hdp_pkg::RESP_OKAY);
    join
    st(fb(1) | bz(2'h3), fb(1));
    wr(hdp_pkg::OFS_SET, fb(2), hdp_pkg::RESP_OKAY);
    wr(hdp_pkg::OFS_CLR, fb(1), hdp_pkg::RESP_OKAY);
    fork
      u_hdp_host_model.inXfer(6);
      wr(hdp_pkg::OFS_SET, fb(0), hdp_pkg::RESP_OKAY);
    join
    repeat (2) @(posedge mclk);
    st(fb(0) | fb(1) | bz(2'h3), fb(1));
    wr(hdp_pkg::OFS_SET, fb(0), hdp_pkg::RESP_OKAY);
    repeat (3) @(posedge mclk);
    st(fb(0), 32'h0000_0000);
    $display("test in kill done");
    wr(hdp_pkg::OFS_CTRL, fb(hdp_pkg::BIT_EP_EN) | fb(hdp_pkg::BIT_DIR_IN) | fb(hdp_pkg::BIT_ISO),
       hdp_pkg::RESP_OKAY);
    u_hdp_host_model.inXfer(1);
    st(fb(hdp_pkg::BIT_FLOW) | bz(2'h3), fb(hdp_pkg::BIT_FLOW));
    $display("test iso in done");
    summarize();
  end
endmodule
